// >>> aux_band_defs.svh
// Purpose: Addresses, field positions and reset values of the aux and band registers
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef AUX_BAND_DEFS_SVH
`define AUX_BAND_DEFS_SVH

`define AUX_CTRL_ADDR 8'h07
`define BAND_CTRL_ADDR 8'h08
`define AUX_RDBK_ADDR 8'hf7
`define BAND_RDBK_ADDR 8'hf8

`define REG_WIDTH 8

`define AUX_DC_METER_BIT 7
`define AUX_INSTAB_BIT 6
`define AUX_RF_DET_BIT 5
`define AUX_MEAS_SEL_BIT 4
`define AUX_GAIN_HI_BIT 3
`define AUX_GAIN_LO_BIT 2
`define AUX_PROBE_HI_BIT 1
`define AUX_PROBE_LO_BIT 0

`define BAND_LO_DIV_BIT 4
`define BAND_SEL_HI_BIT 1
`define BAND_SEL_LO_BIT 0
`define BAND_DEFINED_MASK 8'h13
`define BAND_RESERVED_MASK 8'hec

`define AUX_RESET_VAL 8'h00
`define BAND_RESET_VAL 8'h00

`define GAIN_6DB 2'h0
`define GAIN_12DB 2'h1
`define GAIN_18DB 2'h2
`define GAIN_24DB 2'h3

`define PROBE_Q_NEG 2'h0
`define PROBE_I_NEG 2'h1
`define PROBE_I_PAIR 2'h2
`define PROBE_Q_PAIR 2'h3

`define BAND_BELOW_500 2'h0
`define BAND_ABOVE_500 2'h1

`endif

// >>> aux_band_pkg.sv
// Purpose: Types shared by the aux and band register bank
// Assumes: Field positions in aux_band_defs.svh match these layouts
// Notes: Packed so a struct casts straight to a register byte
package aux_band_pkg;

   typedef struct packed {
      logic dc_offset_meter_power;
      logic instability_detector_power;
      logic rf_detector_power;
      logic measurement_output_select;
      logic instability_gain_sel_hi;
      logic instability_gain_sel_lo;
      logic offset_probe_sel_hi;
      logic offset_probe_sel_lo;
   } aux_ctrl_t;

   typedef struct packed {
      logic [2:0] rsvd_hi;
      logic lo_divider_select;
      logic [1:0] rsvd_lo;
      logic loop_band_sel_hi;
      logic loop_band_sel_lo;
   } band_ctrl_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      DEC_NONE,
      DEC_AUX,
      DEC_BAND,
      DEC_BAD
   } dec_sel_t;

endpackage

// >>> code_onehot.sv
// Purpose: Registered one-hot decode of a two-bit select code
// Assumes: Same clock and enable as the register bank
// Notes: Output is one cycle behind the code
`timescale 1ns/10ps
module code_onehot (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic [1:0] i_code,
   output logic [3:0] o_onehot
);

   logic [3:0] onehot_ff;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_bit
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               onehot_ff[g] <= (g == 0) ? 1'b1 : 1'b0;
            end else if (i_ce) begin
               onehot_ff[g] <= (i_code == 2'(g));
            end
         end
      end
   endgenerate

   assign o_onehot = onehot_ff;

endmodule

// >>> aux_band_regs.sv
// Purpose: Aux block and loop band control registers with readback copies
// Assumes: Requests come decoded from the serial control port on I_MCLK
// Notes: Readback answers one cycle after the read strobe
`timescale 1ns/10ps
`include "aux_band_defs.svh"
module aux_band_regs (
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   input wire logic I_WR_STB,
   input wire logic I_RD_STB,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   output logic [7:0] O_RDATA,
   output logic O_RVALID,
   output logic O_ADDR_ERR,
   output logic O_RSVD_WRITE,
   output logic O_DC_OFFSET_METER_POWER,
   output logic O_INSTABILITY_DETECTOR_POWER,
   output logic O_RF_DETECTOR_POWER,
   output logic O_MEASUREMENT_OUTPUT_SELECT,
   output logic [1:0] O_INSTABILITY_GAIN_SEL,
   output logic [1:0] O_OFFSET_PROBE_SEL,
   output logic [3:0] O_INSTABILITY_GAIN_ONEHOT,
   output logic [3:0] O_OFFSET_PROBE_ONEHOT,
   output logic O_REF_SUPPLY_DEMAND,
   output logic O_LO_DIVIDER_SELECT,
   output logic [1:0] O_LOOP_BAND_SEL,
   output logic O_LOOP_BAND_INVALID
);

   aux_band_pkg::reg_req_t req;
   aux_band_pkg::aux_ctrl_t aux_ff;
   aux_band_pkg::aux_ctrl_t nxt_aux;
   aux_band_pkg::band_ctrl_t band_ff;
   aux_band_pkg::band_ctrl_t nxt_band;
   aux_band_pkg::dec_sel_t wr_sel;
   aux_band_pkg::dec_sel_t rd_sel;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic rvalid_ff;
   logic addr_err_ff;
   logic nxt_addr_err;
   logic rsvd_write_ff;
   logic nxt_rsvd_write;
   logic ref_demand_ff;
   logic band_invalid_ff;
   logic nxt_band_invalid;
   logic wr_band_legal;
   logic nxt_ref_demand;
   logic [1:0] gain_code;
   logic [1:0] probe_code;
   logic [1:0] band_code;
   logic [3:0] gain_onehot;
   logic [3:0] probe_onehot;

   // Serial decoder runs on this clock, so no synchroniser here
   assign req.wr = I_WR_STB;
   assign req.rd = I_RD_STB;
   assign req.addr = I_ADDR;
   assign req.wdata = I_WDATA;

   // Write address decode; readback addresses are not writable
   always_comb begin
      wr_sel = aux_band_pkg::DEC_NONE;
      if (req.wr) begin
         case (req.addr)
            `AUX_CTRL_ADDR: begin
               wr_sel = aux_band_pkg::DEC_AUX;
            end
            `BAND_CTRL_ADDR: begin
               wr_sel = aux_band_pkg::DEC_BAND;
            end
            default: begin
               wr_sel = aux_band_pkg::DEC_BAD;
            end
         endcase
      end
   end

   // Read address decode; write addresses are not readable
   always_comb begin
      rd_sel = aux_band_pkg::DEC_NONE;
      if (req.rd) begin
         case (req.addr)
            `AUX_RDBK_ADDR: begin
               rd_sel = aux_band_pkg::DEC_AUX;
            end
            `BAND_RDBK_ADDR: begin
               rd_sel = aux_band_pkg::DEC_BAND;
            end
            default: begin
               rd_sel = aux_band_pkg::DEC_BAD;
            end
         endcase
      end
   end

   // Aux register next value; all eight bits are defined
   always_comb begin
      nxt_aux = aux_ff;
      if (wr_sel == aux_band_pkg::DEC_AUX) begin
         nxt_aux = aux_band_pkg::aux_ctrl_t'(req.wdata);
      end
   end

   // Only defined bits are kept, so reserved bits always read zero
   always_comb begin
      nxt_band = band_ff;
      if (wr_sel == aux_band_pkg::DEC_BAND) begin
         nxt_band = aux_band_pkg::band_ctrl_t'(req.wdata & `BAND_DEFINED_MASK);
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         aux_ff <= aux_band_pkg::aux_ctrl_t'(`AUX_RESET_VAL);
      end else if (I_CE) begin
         aux_ff <= nxt_aux;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         band_ff <= aux_band_pkg::band_ctrl_t'(`BAND_RESET_VAL);
      end else if (I_CE) begin
         band_ff <= nxt_band;
      end
   end

   // Readback mux; a read in the write cycle sees the old value
   always_comb begin
      nxt_rdata = 8'h00;
      case (rd_sel)
         aux_band_pkg::DEC_AUX: begin
            nxt_rdata = aux_ff;
         end
         aux_band_pkg::DEC_BAND: begin
            nxt_rdata = band_ff;
         end
         aux_band_pkg::DEC_NONE: begin
            nxt_rdata = rdata_ff;
         end
         default: begin
            nxt_rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         rdata_ff <= 8'h00;
      end else if (I_CE) begin
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         rvalid_ff <= 1'b0;
      end else if (I_CE) begin
         rvalid_ff <= req.rd;
      end
   end

   // Unmapped read or write answers with a one-cycle error pulse
   always_comb begin
      nxt_addr_err = 1'b0;
      if (wr_sel == aux_band_pkg::DEC_BAD) begin
         nxt_addr_err = 1'b1;
      end
      if (rd_sel == aux_band_pkg::DEC_BAD) begin
         nxt_addr_err = 1'b1;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         addr_err_ff <= 1'b0;
      end else if (I_CE) begin
         addr_err_ff <= nxt_addr_err;
      end
   end

   // Only two band codes are named; the others are reserved
   always_comb begin
      wr_band_legal = 1'b0;
      case (req.wdata[`BAND_SEL_HI_BIT:`BAND_SEL_LO_BIT])
         `BAND_BELOW_500: begin
            wr_band_legal = 1'b1;
         end
         `BAND_ABOVE_500: begin
            wr_band_legal = 1'b1;
         end
         default: begin
            wr_band_legal = 1'b0;
         end
      endcase
   end

   // Host misuse is flagged, not trapped: bits are dropped, codes stored
   always_comb begin
      nxt_rsvd_write = 1'b0;
      if (wr_sel == aux_band_pkg::DEC_BAND) begin
         if ((req.wdata & `BAND_RESERVED_MASK) != 8'h00) begin
            nxt_rsvd_write = 1'b1;
         end
         if (!wr_band_legal) begin
            nxt_rsvd_write = 1'b1;
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         rsvd_write_ff <= 1'b0;
      end else if (I_CE) begin
         rsvd_write_ff <= nxt_rsvd_write;
      end
   end

   // Judged on the stored code, so the flag tracks the register
   always_comb begin
      nxt_band_invalid = 1'b1;
      case ({nxt_band.loop_band_sel_hi, nxt_band.loop_band_sel_lo})
         `BAND_BELOW_500: begin
            nxt_band_invalid = 1'b0;
         end
         `BAND_ABOVE_500: begin
            nxt_band_invalid = 1'b0;
         end
         default: begin
            nxt_band_invalid = 1'b1;
         end
      endcase
   end

   // Reserved band codes are stored and driven out as written; they raise the invalid flag and the reserved-write pulse
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         band_invalid_ff <= 1'b0;
      end else if (I_CE) begin
         band_invalid_ff <= nxt_band_invalid;
      end
   end

   // Reference supply is drawn while either measuring block is on
   always_comb begin
      nxt_ref_demand = 1'b0;
      if (nxt_aux.dc_offset_meter_power || nxt_aux.rf_detector_power) begin
         nxt_ref_demand = 1'b1;
      end
   end

   // Taken from the next value so it moves with the register
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         ref_demand_ff <= 1'b0;
      end else if (I_CE) begin
         ref_demand_ff <= nxt_ref_demand;
      end
   end

   assign gain_code = {aux_ff.instability_gain_sel_hi, aux_ff.instability_gain_sel_lo};
   assign probe_code = {aux_ff.offset_probe_sel_hi, aux_ff.offset_probe_sel_lo};
   assign band_code = {band_ff.loop_band_sel_hi, band_ff.loop_band_sel_lo};

   // Gain steps 6, 12, 18, 24dB on one-hot lines
   code_onehot u_gain_dec (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .i_code(gain_code),
      .o_onehot(gain_onehot)
   );

   // Q-neg, I-neg, I pair, Q pair on one-hot lines
   code_onehot u_probe_dec (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .i_code(probe_code),
      .o_onehot(probe_onehot)
   );

   // Direct field outputs come straight from the register flops
   assign O_DC_OFFSET_METER_POWER = aux_ff.dc_offset_meter_power;
   assign O_INSTABILITY_DETECTOR_POWER = aux_ff.instability_detector_power;
   assign O_RF_DETECTOR_POWER = aux_ff.rf_detector_power;
   assign O_MEASUREMENT_OUTPUT_SELECT = aux_ff.measurement_output_select;
   assign O_INSTABILITY_GAIN_SEL = gain_code;
   assign O_OFFSET_PROBE_SEL = probe_code;
   assign O_INSTABILITY_GAIN_ONEHOT = gain_onehot;
   assign O_OFFSET_PROBE_ONEHOT = probe_onehot;
   assign O_LO_DIVIDER_SELECT = band_ff.lo_divider_select;
   assign O_LOOP_BAND_SEL = band_code;
   assign O_LOOP_BAND_INVALID = band_invalid_ff;
   assign O_REF_SUPPLY_DEMAND = ref_demand_ff;
   assign O_RDATA = rdata_ff;
   assign O_RVALID = rvalid_ff;
   assign O_ADDR_ERR = addr_err_ff;
   assign O_RSVD_WRITE = rsvd_write_ff;

endmodule

// >>> aux_band_regs_checker.sv
// Purpose: Port checks for the aux and band register bank
// Assumes: One clock, sync active-low reset
// Notes: Bound to every aux_band_regs instance
`timescale 1ns/10ps
`include "aux_band_defs.svh"
module aux_band_regs_checker (
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   input wire logic I_WR_STB,
   input wire logic I_RD_STB,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic [7:0] O_RDATA,
   input wire logic O_RVALID,
   input wire logic O_ADDR_ERR,
   input wire logic O_DC_OFFSET_METER_POWER,
   input wire logic O_INSTABILITY_DETECTOR_POWER,
   input wire logic O_RF_DETECTOR_POWER,
   input wire logic O_MEASUREMENT_OUTPUT_SELECT,
   input wire logic [1:0] O_INSTABILITY_GAIN_SEL,
   input wire logic [1:0] O_OFFSET_PROBE_SEL,
   input wire logic [3:0] O_INSTABILITY_GAIN_ONEHOT,
   input wire logic [3:0] O_OFFSET_PROBE_ONEHOT,
   input wire logic O_LO_DIVIDER_SELECT,
   input wire logic [1:0] O_LOOP_BAND_SEL
);
   logic wa, wb, ra, rb, ru;
   logic [7:0] aux, band;
   assign wa = I_CE && I_WR_STB && I_ADDR == `AUX_CTRL_ADDR;
   assign wb = I_CE && I_WR_STB && I_ADDR == `BAND_CTRL_ADDR;
   assign ra = I_CE && I_RD_STB && I_ADDR == `AUX_RDBK_ADDR;
   assign rb = I_CE && I_RD_STB && I_ADDR == `BAND_RDBK_ADDR;
   assign ru = I_CE && I_RD_STB && !ra && !rb;
   assign aux = {O_DC_OFFSET_METER_POWER, O_INSTABILITY_DETECTOR_POWER, O_RF_DETECTOR_POWER,
      O_MEASUREMENT_OUTPUT_SELECT, O_INSTABILITY_GAIN_SEL, O_OFFSET_PROBE_SEL};
   assign band = {3'h0, O_LO_DIVIDER_SELECT, 2'h0, O_LOOP_BAND_SEL};
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RST_N);
   AST_AUX_WR: assert property (wa |=> aux == $past(I_WDATA))
      else $error("aux write lost");
   AST_AUX_HOLD: assert property (!wa |=> $stable(aux)) else $error("aux changed");
   // Read sees the value from before a same-cycle write
   AST_AUX_RD: assert property (ra |=> O_RVALID && O_RDATA == $past(aux)) else $error("aux readback");
   AST_BAND_WR: assert property (wb |=> band == ($past(I_WDATA) & 8'h13)) else $error("band write");
   AST_BAND_RD: assert property (rb |=> O_RVALID && O_RDATA == $past(band)) else $error("band readback");
   AST_BAD_RD: assert property (ru |=> O_RVALID && O_ADDR_ERR && O_RDATA == 8'h00)
      else $error("bad read");
   AST_GAIN_HOT: assert property (
      $past(I_CE) && $past(I_RST_N) |-> O_INSTABILITY_GAIN_ONEHOT == 4'h1 << $past(O_INSTABILITY_GAIN_SEL))
      else $error("gain decode");
   AST_PROBE_HOT: assert property (
      $past(I_CE) && $past(I_RST_N) |-> O_OFFSET_PROBE_ONEHOT == 4'h1 << $past(O_OFFSET_PROBE_SEL))
      else $error("probe decode");
   AST_RESET: assert property (disable iff (1'b0) !I_RST_N |=> aux == 8'h00 && band == 8'h00)
      else $error("reset");
   cover property (wa);
   cover property (rb);
   cover property (ru);
endmodule
bind aux_band_regs aux_band_regs_checker aux_band_regs_checker_i (.I_MCLK, .I_RST_N, .I_CE, .I_WR_STB,
   .I_RD_STB, .I_ADDR, .I_WDATA, .O_RDATA, .O_RVALID, .O_ADDR_ERR, .O_DC_OFFSET_METER_POWER,
   .O_INSTABILITY_DETECTOR_POWER, .O_RF_DETECTOR_POWER, .O_MEASUREMENT_OUTPUT_SELECT, .O_INSTABILITY_GAIN_SEL,
   .O_OFFSET_PROBE_SEL, .O_INSTABILITY_GAIN_ONEHOT, .O_OFFSET_PROBE_ONEHOT, .O_LO_DIVIDER_SELECT, .O_LOOP_BAND_SEL);

// >>> host_port_model.sv
// Purpose: Host side of the register port
// Assumes: One strobe per access, taken on the next edge
// Notes: Sends whatever data the bench hands it
`timescale 1ns/10ps
module host_port_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // Reserved bits are zero unless the bench asks otherwise
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      // Inverted leftovers so stale lines never repeat the access; ~a of a control address is a readback address
      o_addr <= ~a;
      o_wdata <= ~d;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int n;
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1;
      for (n = 0; n < 4 && i_rvalid !== 1'b1; n++) begin
         @(posedge i_clk);
         #1;
      end
      ok = (i_rvalid === 1'b1);
      d = i_rdata;
   endtask
endmodule

// >>> aux_band_regs_bench.sv
// Purpose: Directed test of the aux and band register bank
// Assumes: Host model drives the register port
// Notes: No random stimulus
`timescale 1ns/10ps
`include "aux_band_defs.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module aux_band_regs_bench;
   logic mclk, rst_n, ce, wr, rd, rvalid, aerr, rsvd, dcp, isp, rfp, meas, refd, lodiv, binv;
   logic [7:0] addr, wdata, rdata, d;
   logic [1:0] gsel, psel, bsel;
   logic [3:0] goh, poh;
   int errors = 0;
   int n_checks = 0;
   int k;
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   host_port_model host_port_model_i (.i_clk(mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_wdata(wdata));
   aux_band_regs aux_band_regs_i (.I_MCLK(mclk), .I_RST_N(rst_n), .I_CE(ce), .I_WR_STB(wr), .I_RD_STB(rd),
      .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid), .O_ADDR_ERR(aerr), .O_RSVD_WRITE(rsvd),
      .O_DC_OFFSET_METER_POWER(dcp), .O_INSTABILITY_DETECTOR_POWER(isp), .O_RF_DETECTOR_POWER(rfp),
      .O_MEASUREMENT_OUTPUT_SELECT(meas), .O_INSTABILITY_GAIN_SEL(gsel), .O_OFFSET_PROBE_SEL(psel),
      .O_INSTABILITY_GAIN_ONEHOT(goh), .O_OFFSET_PROBE_ONEHOT(poh), .O_REF_SUPPLY_DEMAND(refd),
      .O_LO_DIVIDER_SELECT(lodiv), .O_LOOP_BAND_SEL(bsel), .O_LOOP_BAND_INVALID(binv));
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      logic ok;
      host_port_model_i.rd_reg(a, v, ok);
      if (ok !== 1'b1) begin
         errors++;
         $display("[ERR] %0t read timed out", $time);
         final_report();
      end else begin
         `CHK(v, e)
      end
   endtask
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      `CHK({dcp, isp, rfp, meas, gsel, psel, refd, lodiv, bsel}, 12'h000)
      `CHK({goh, poh}, 8'h11)
      `CHK({rvalid, aerr, rsvd, binv, rdata}, 12'h000)
      rdc(`AUX_RDBK_ADDR, 8'h00);
      rdc(`BAND_RDBK_ADDR, 8'h00);
      $display("test reset done");
      // Walks each power bit and every gain and probe code
      for (k = 0; k < 4; k++) begin
         d = (8'h10 << k) | {4'h0, k[1:0], k[1:0]};
         host_port_model_i.wr_reg(`AUX_CTRL_ADDR, d);
         `CHK({dcp, isp, rfp, meas, gsel, psel}, d)
         `CHK(refd, d[7] | d[5])
         @(posedge mclk);
         #1;
         `CHK({goh, poh}, {4'h1 << k, 4'h1 << k})
         rdc(`AUX_RDBK_ADDR, d);
      end
      $display("test aux done");
      for (k = 0; k < 4; k++) begin
         d = {3'h0, k[0], 2'h0, k[1:0]};
         host_port_model_i.wr_reg(`BAND_CTRL_ADDR, d);
         `CHK({lodiv, bsel, binv, rsvd}, {k[0], k[1:0], k[1], k[1]})
         rdc(`BAND_RDBK_ADDR, d);
      end
      host_port_model_i.wr_reg(`BAND_CTRL_ADDR, 8'hff);
      `CHK({rsvd, lodiv, bsel}, 4'hf)
      rdc(`BAND_RDBK_ADDR, 8'h13);
      $display("test band done");
      host_port_model_i.wr_reg(`AUX_RDBK_ADDR, 8'h00);
      `CHK(aerr, 1'b1)
      rdc(`AUX_CTRL_ADDR, 8'h00);
      @(posedge mclk);
      ce <= 1'b0;
      host_port_model_i.wr_reg(`AUX_CTRL_ADDR, 8'h00);
      @(posedge mclk);
      ce <= 1'b1;
      rdc(`AUX_RDBK_ADDR, 8'h8f);
      $display("test refused done");
      // Second reset with both registers loaded
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      `CHK({dcp, isp, rfp, meas, gsel, psel, refd, lodiv, bsel, binv}, 13'h0000)
      `CHK({goh, poh}, 8'h11)
      rdc(`AUX_RDBK_ADDR, 8'h00);
      rdc(`BAND_RDBK_ADDR, 8'h00);
      $display("test reset again done");
      final_report();
   end
endmodule
